/* File: pwm_defines.vh */
`ifndef PWM_DEFINES_VH
`define PWM_DEFINES_VH
`define CNT_W         16
`define MODE_W        3
`define MODE_STOP     3'h0
`define MODE_PWM1     3'h1
`define MODE_PWM2     3'h2
`define MODE_RSYNC    3'h3
`define MODE_COMP1    3'h4
`define MODE_COMP2    3'h5
`define MODE_COMP3    3'h6
`define CNT_RST       16'h0000
`define DT_RST        16'h0000
`define PERIOD_RST    16'hFFFF
`define CMP_RST       16'h0000
`endif

/* File: dead_time_gen.v */
`timescale 1ns/10ps
`include "pwm_defines.vh"
module dead_time_gen (
  input  wire                clk,
  input  wire                rst_sync_n,
  input  wire                enable,
  input  wire [`CNT_W-1:0]   dead_time,
  input  wire                raw,
  output reg                 pos_r,
  output reg                 neg_r
);
  reg              raw_r;
  reg [`CNT_W-1:0] dt_cnt_r;
  // One shared delay serves both edges of the pair.
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      raw_r    <= 1'b0;
      dt_cnt_r <= `CNT_RST;
      pos_r    <= 1'b0;
      neg_r    <= 1'b0;
    end else begin
      raw_r <= raw;
      if (!enable) begin
        dt_cnt_r <= `CNT_RST;
        pos_r    <= raw;
        neg_r    <= ~raw;
      end else if (raw != raw_r) begin
        dt_cnt_r <= dead_time;
        pos_r    <= 1'b0;
        neg_r    <= 1'b0;
        if (dead_time == `CNT_RST) begin
          pos_r <= raw;
          neg_r <= ~raw;
        end
      end else if (dt_cnt_r > 16'h0001) begin
        dt_cnt_r <= dt_cnt_r - 16'h0001;
      end else begin
        dt_cnt_r <= `CNT_RST;
        pos_r    <= raw;
        neg_r    <= ~raw;
      end
    end
  end
endmodule

/* File: pwm_timer.v */
`timescale 1ns/10ps
`include "pwm_defines.vh"
module pwm_timer (
  input  wire                clk,
  input  wire                rst_n,
  input  wire [`MODE_W-1:0]  mode,
  input  wire [`CNT_W-1:0]   period,
  input  wire [`CNT_W-1:0]   compare_value_register,
  input  wire [`CNT_W-1:0]   compare_buffer_register,
  input  wire [`CNT_W-1:0]   compare_double_buffer_register,
  input  wire                buffer_write,
  input  wire [`CNT_W-1:0]   dead_time,
  input  wire                pin_force_en,
  input  wire                pin_output_level_control,
  output reg  [`CNT_W-1:0]   count_r,
  output reg                 count_down_r,
  output reg                 crest_r,
  output reg                 trough_r,
  output reg                 pwm_r,
  output reg                 pwm_pos_r,
  output reg                 pwm_neg_r,
  output reg  [`CNT_W-1:0]   active_compare_r
);
  reg              rst_s1_r;
  reg              rst_sync_n;
  reg [`CNT_W-1:0] down_phase_temporary_register;
  reg [`CNT_W-1:0] up_phase_temporary_register;
  reg [`CNT_W-1:0] down_cmp_r;
  reg [`CNT_W-1:0] up_cmp_r;
  reg              comp_r;
  reg              raw_nxt;
  reg [`CNT_W-1:0] cmp_sel;
  reg [`CNT_W-1:0] count_nxt;
  reg              count_down_nxt;
  reg              crest_nxt;
  reg              trough_nxt;
  reg [`CNT_W-1:0] dead_time_r;
  wire             dt_pos;
  wire             dt_neg;

  function is_comp;
    input [`MODE_W-1:0] m;
    begin
      is_comp = (m == `MODE_COMP1) || (m == `MODE_COMP2) || (m == `MODE_COMP3);
    end
  endfunction

  // Steps down but never wraps below zero, even with a zero period.
  function [`CNT_W-1:0] step_down;
    input [`CNT_W-1:0] v;
    begin
      if (v == `CNT_RST) begin
        step_down = `CNT_RST;
      end else begin
        step_down = v - 16'h0001;
      end
    end
  endfunction

  function [`CNT_W-1:0] step_up;
    input [`CNT_W-1:0] v;
    begin
      step_up = v + 16'h0001;
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  // Counter: sawtooth 0..period, or triangle 0..period..0.
  always @* begin
    count_nxt      = count_r;
    count_down_nxt = count_down_r;
    crest_nxt      = 1'b0;
    trough_nxt     = 1'b0;
    if (mode == `MODE_STOP) begin
      count_nxt      = `CNT_RST;
      count_down_nxt = 1'b0;
    end else if (is_comp(mode)) begin
      if (!count_down_r) begin
        if (count_r >= period) begin
          count_down_nxt = 1'b1;
          count_nxt      = step_down(count_r);
          crest_nxt      = 1'b1;
        end else begin
          count_nxt = step_up(count_r);
        end
      end else begin
        if (count_r == `CNT_RST) begin
          count_down_nxt = 1'b0;
          count_nxt      = step_up(count_r);
          trough_nxt     = 1'b1;
        end else begin
          count_nxt = step_down(count_r);
        end
      end
    end else begin
      count_down_nxt = 1'b0;
      if (count_r >= period) begin
        count_nxt  = `CNT_RST;
        trough_nxt = 1'b1;
      end else begin
        count_nxt = step_up(count_r);
      end
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_r      <= `CNT_RST;
      count_down_r <= 1'b0;
      crest_r      <= 1'b0;
      trough_r     <= 1'b0;
      comp_r       <= 1'b0;
    end else begin
      count_r      <= count_nxt;
      count_down_r <= count_down_nxt;
      crest_r      <= crest_nxt;
      trough_r     <= trough_nxt;
      comp_r       <= is_comp(mode);
    end
  end

  // Double buffer: buffer feeds down phase, double buffer feeds up phase.
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      down_phase_temporary_register <= `CMP_RST;
      up_phase_temporary_register   <= `CMP_RST;
      down_cmp_r                    <= `CMP_RST;
      up_cmp_r                      <= `CMP_RST;
    end else begin
      if (buffer_write) begin
        down_phase_temporary_register <= compare_buffer_register;
        up_phase_temporary_register   <= compare_double_buffer_register;
      end
      if (mode == `MODE_COMP3) begin
        if (crest_nxt) begin
          down_cmp_r <= down_phase_temporary_register;
        end
        if (trough_nxt) begin
          up_cmp_r <= up_phase_temporary_register;
        end
      end else begin
        down_cmp_r <= compare_value_register;
        up_cmp_r   <= compare_value_register;
      end
    end
  end

  always @* begin
    cmp_sel = count_down_r ? down_cmp_r : up_cmp_r;
    raw_nxt = 1'b0;
    if (mode == `MODE_STOP) begin
      raw_nxt = 1'b0;
    end else if (is_comp(mode)) begin
      if (cmp_sel == `CMP_RST) begin
        raw_nxt = 1'b1;
      end else if (cmp_sel >= period) begin
        raw_nxt = 1'b0;
      end else begin
        raw_nxt = (count_r >= cmp_sel);
      end
    end else if (compare_value_register > period) begin
      raw_nxt = 1'b0;
    end else if (compare_value_register == period) begin
      raw_nxt = 1'b1;
    end else begin
      raw_nxt = (count_r < compare_value_register);
    end
    if (pin_force_en) begin
      raw_nxt = pin_output_level_control;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwm_r            <= 1'b0;
      pwm_pos_r        <= 1'b0;
      pwm_neg_r        <= 1'b0;
      active_compare_r <= `CMP_RST;
    end else begin
      pwm_r            <= raw_nxt;
      pwm_pos_r        <= dt_pos;
      pwm_neg_r        <= dt_neg;
      active_compare_r <= cmp_sel;
    end
  end

  // Dead time is taken only while stopped, so a running pair never sees it move.
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dead_time_r <= `DT_RST;
    end else if (mode == `MODE_STOP) begin
      dead_time_r <= dead_time;
    end
  end

  // Dead time applies only in complementary modes.
  dead_time_gen u_dt (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .enable     (comp_r),
    .dead_time  (dead_time_r),
    .raw        (pwm_r),
    .pos_r      (dt_pos),
    .neg_r      (dt_neg)
  );
endmodule

/* File: gate_drive_model.sv */
`timescale 1ns/10ps
// Gate driver stand-in that counts the cycles each switch is commanded on.
module gate_drive_model (
  input  wire        clk,
  input  wire        clear,
  input  wire        pwm_pos_r,
  input  wire        pwm_neg_r,
  output reg  [15:0] hi_on_r,
  output reg  [15:0] lo_on_r
);
  always @(posedge clk) begin
    hi_on_r <= clear ? 16'h0000 : hi_on_r + {15'h0000, pwm_pos_r};
    lo_on_r <= clear ? 16'h0000 : lo_on_r + {15'h0000, pwm_neg_r};
  end
endmodule

/* File: pwm_timer_monitor.sv */
`timescale 1ns/10ps
module pwm_timer_monitor (
  input wire        clk,
  input wire        rst_n,
  input wire        pin_force_en,
  input wire        pwm_r,
  input wire        pwm_pos_r,
  input wire        pwm_neg_r,
  input wire [2:0]  mode,
  input wire [15:0] period,
  input wire [15:0] compare_value_register,
  input wire [15:0] dead_time,
  input wire [15:0] count_r
);
  reg  [51:0] cfg_r;
  reg  [2:0]  q_r;
  wire [51:0] cfg  = {pin_force_en, mode, period, compare_value_register, dead_time};
  wire        calm = q_r == 3'h7 && cfg == cfg_r && !pin_force_en;
  wire        saw  = calm && (mode == 3'h1 || mode == 3'h2);
  wire        tri2 = calm && (mode == 3'h4 || mode == 3'h5);
  // Counts settled cycles since the last configuration change.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= 52'h0;
      q_r   <= 3'h0;
    end else begin
      cfg_r <= cfg;
      q_r   <= (cfg != cfg_r) ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_saw_wrap: assert property (saw && count_r == period |=> count_r == 16'h0000)
    else $error("sawtooth did not wrap");
  chk_saw_step: assert property (saw && count_r < period |=> count_r == $past(count_r) + 16'h0001)
    else $error("sawtooth did not step");
  chk_comp_turn: assert property (tri2 && count_r == period |=> count_r == $past(period) - 16'h0001)
    else $error("triangle did not turn");
  chk_full_duty: assert property (saw && compare_value_register == period |-> pwm_r)
    else $error("full duty lost");
  chk_zero_duty: assert property (saw && compare_value_register > period |-> !pwm_r)
    else $error("zero duty lost");
  chk_comp_full: assert property (tri2 && compare_value_register == 16'h0000 |-> pwm_r)
    else $error("triangle full duty lost");
  chk_comp_zero: assert property (tri2 && compare_value_register == period |-> !pwm_r)
    else $error("triangle zero duty lost");
  chk_no_overlap: assert property (!(pwm_pos_r && pwm_neg_r))
    else $error("both switches on");
  chk_dead_band: assert property (tri2 && dead_time == 16'h0002 && $fell(pwm_pos_r) |-> !pwm_neg_r [*2])
    else $error("dead band too short");
  chk_direct_pair: assert property (saw |-> pwm_neg_r != pwm_pos_r)
    else $error("dead time outside triangle modes");
endmodule
bind pwm_timer pwm_timer_monitor i_mon (
  .clk(clk), .rst_n(rst_n), .pin_force_en(pin_force_en), .pwm_r(pwm_r), .pwm_pos_r(pwm_pos_r),
  .pwm_neg_r(pwm_neg_r), .mode(mode), .period(period), .compare_value_register(compare_value_register),
  .dead_time(dead_time), .count_r(count_r)
);

/* File: pwm_timer_test.sv */
`timescale 1ns/10ps
module pwm_timer_test;
  reg         clk = 1'b0, rst_n = 1'b0, buffer_write = 1'b0, pin_force_en = 1'b0, clear = 1'b0;
  reg         pin_output_level_control = 1'b1;
  reg  [2:0]  mode = 3'h0;
  reg  [15:0] period = 16'h0003, compare_value_register = 16'h0000, dead_time = 16'h0000;
  reg  [15:0] compare_buffer_register = 16'h0000, compare_double_buffer_register = 16'h0000;
  wire [15:0] count_r, active_compare_r, hi_on_r, lo_on_r;
  wire        count_down_r, crest_r, trough_r, pwm_r, pwm_pos_r, pwm_neg_r;
  integer     num_errors = 0, samples_checked = 0, i;
  always #50 clk = ~clk;
  pwm_timer i_dut (
    .clk(clk), .rst_n(rst_n), .mode(mode), .period(period),
    .compare_value_register(compare_value_register), .compare_buffer_register(compare_buffer_register),
    .compare_double_buffer_register(compare_double_buffer_register), .buffer_write(buffer_write),
    .dead_time(dead_time), .pin_force_en(pin_force_en), .pin_output_level_control(pin_output_level_control),
    .count_r(count_r), .count_down_r(count_down_r), .crest_r(crest_r), .trough_r(trough_r), .pwm_r(pwm_r),
    .pwm_pos_r(pwm_pos_r), .pwm_neg_r(pwm_neg_r), .active_compare_r(active_compare_r)
  );
  gate_drive_model i_drv (
    .clk(clk), .clear(clear), .pwm_pos_r(pwm_pos_r), .pwm_neg_r(pwm_neg_r), .hi_on_r(hi_on_r), .lo_on_r(lo_on_r)
  );
  task results;
    begin
      $display("errors %0d of %0d comparisons", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Dead time is only changed while stopped; windows span whole periods.
  task run(input [2:0] m, input [7:0] p, c, dt, n, eh, el);
    begin
      mode = 3'h0;
      @(negedge clk);
      dead_time = {8'h00, dt};
      period = {8'h00, p};
      compare_value_register = {8'h00, c};
      @(negedge clk);
      mode = m;
      repeat (12) @(negedge clk);
      clear = 1'b1;
      @(negedge clk);
      clear = 1'b0;
      repeat (n) @(negedge clk);
      check("high side", hi_on_r, {8'h00, eh});
      check("low side", lo_on_r, {8'h00, el});
    end
  endtask
  task turn(input top, input [15:0] exp);
    begin
      for (i = 0; i < 20 && (top ? crest_r : trough_r) !== 1'b1; i = i + 1) @(negedge clk);
      if (i == 20) begin
        num_errors = num_errors + 1;
        results;
      end else begin
        repeat (2) @(negedge clk);
        check("active compare", active_compare_r, exp);
        check("count direction", {15'h0000, count_down_r}, {15'h0000, top});
      end
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    run(3'h1, 8'h3, 8'h2, 8'h0, 8'h8, 8'h4, 8'h4);
    run(3'h1, 8'h3, 8'h2, 8'h2, 8'h8, 8'h4, 8'h4);
    run(3'h2, 8'h3, 8'h3, 8'h0, 8'h8, 8'h8, 8'h0);
    run(3'h1, 8'h3, 8'h4, 8'h0, 8'h8, 8'h0, 8'h8);
    pin_force_en = 1'b1;
    run(3'h1, 8'h3, 8'h4, 8'h0, 8'h8, 8'h8, 8'h0);
    pin_force_en = 1'b0;
    run(3'h3, 8'h4, 8'h2, 8'h0, 8'hA, 8'h4, 8'h6);
    run(3'h4, 8'h4, 8'h2, 8'h0, 8'h10, 8'hA, 8'h6);
    run(3'h5, 8'h4, 8'h0, 8'h0, 8'h10, 8'h10, 8'h0);
    run(3'h4, 8'h4, 8'h4, 8'h0, 8'h10, 8'h0, 8'h10);
    run(3'h5, 8'h4, 8'h2, 8'h2, 8'h10, 8'h6, 8'h2);
    compare_buffer_register = 16'h0001;
    compare_double_buffer_register = 16'h0003;
    // Start the triangle from zero so the first crest follows the buffer write.
    mode = 3'h0;
    buffer_write = 1'b1;
    @(negedge clk);
    buffer_write = 1'b0;
    mode = 3'h6;
    compare_buffer_register = 16'h0002;
    compare_double_buffer_register = 16'h0002;
    turn(1'b1, 16'h0001);
    turn(1'b0, 16'h0003);
    turn(1'b1, 16'h0001);
    results;
  end
endmodule
